// ---- logic/rtcmhp_consts.svh ----
// Offsets, field positions and reset values of the clock/calendar host port
`ifndef RTCMHP_CONSTS_SVH
`define RTCMHP_CONSTS_SVH

// APB register byte offsets
`define RTCMHP_APB_IRQ_STATUS 8'h00
`define RTCMHP_APB_IRQ_MASK   8'h04
`define RTCMHP_APB_CTRL       8'h08
`define RTCMHP_APB_PORT_STAT  8'h0c
`define RTCMHP_APB_EVT_TRIG   8'h10

// APB interrupt status / mask bits
`define RTCMHP_IRQ_W          4
`define RTCMHP_IRQ_HOST_WR    0
`define RTCMHP_IRQ_HOST_RD    1
`define RTCMHP_IRQ_PWR_FAIL   2
`define RTCMHP_IRQ_HOST_INT   3

// APB control and trigger bits
`define RTCMHP_CTRL_PORT_EN   0
`define RTCMHP_CTRL_RST       1'b1
`define RTCMHP_TRIG_ALARM     0
`define RTCMHP_TRIG_UPDATE    1

// Host-side register addresses
`define RTCMHP_REG_A          8'h0a
`define RTCMHP_REG_B          8'h0b
`define RTCMHP_REG_C          8'h0c
`define RTCMHP_REG_D          8'h0d
`define RTCMHP_MEM_DEPTH      128

// Host register fields and reset values
`define RTCMHP_RA_RST         7'h00
`define RTCMHP_RB_RST         8'h00
`define RTCMHP_RB_PER_IE      6
`define RTCMHP_RB_ALM_IE      5
`define RTCMHP_RB_UPD_IE      4
`define RTCMHP_RB_FREQ_EN     3
`define RTCMHP_RB_HRST_CLR    8'h78
`define RTCMHP_RC_SUMMARY     7
`define RTCMHP_RD_PWR_OK      7

// Pin synchroniser vector and divider
`define RTCMHP_SYNC_W         17
`define RTCMHP_SYNC_RST       17'h000e1
`define RTCMHP_DIV_W          14

`endif

// ---- logic/rtcmhp_pkg.sv ----
// Types for the clock/calendar host port
package rtcmhp_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_READ, PH_WRITE} rtcmhp_phase_e;
  typedef logic [7:0] rtcmhp_byte_t;
  typedef logic [2:0] rtcmhp_flags_t;
endpackage

// ---- logic/rtcmhp_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rtcmhp_sync
  import rtcmhp_pkg::*;
#(
  parameter int unsigned    W   = 1,
  parameter logic [W-1:0]   RST = '0
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST;
      q_out    <= RST;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// ---- logic/rtcmhp_top.sv ----
// Multiplexed-bus host port of the clock/calendar peripheral, APB controlled
// Functional notes
// (RQ1) Address phase first, then data phase
// (RQ2) Latch address at address strobe falling edge
// (RQ3) Shared lines bidirectional during data phase
// (RQ4) Host holds select low through data phase
// (RQ5) Address latched regardless of device select
// (RQ6) Drive data at read strobe falling edge
// (RQ7) Capture write data at write strobe rise
// (RQ8) Bus style select must be tied low
// (RQ9) Frequency output follows selected divider tap
// (RQ10) Frequency output low when enable clear
// (RQ11) Interrupt pulled low on enabled flag
// (RQ12) Reading flag register releases interrupt
// (RQ13) Reset pin floats interrupt, refuses access
// (RQ14) RAM enable passes through only with power
// (RQ15) Power fail blocks all host writes
// (RQ16) Flag register read clears every flag
// (RQ17) Low four bits select divider tap
// (RQ18) Captured address held until next latch
`timescale 1ns/100ps
`include "rtcmhp_consts.svh"
module rtcmhp_top
  import rtcmhp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  shared_addr_data_lines_in,
  output logic      [7:0]  shared_addr_data_lines_out,
  output logic             shared_addr_data_lines_oe,
  input  wire logic        addr_latch_strobe,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        dev_select_n,
  input  wire logic        bus_style_select,
  input  wire logic        host_reset_n,
  input  wire logic        main_power_valid,
  input  wire logic        osc_tick_in,
  input  wire logic        ext_ram_enable_in_n,
  output logic             ext_ram_enable_out_n,
  output logic             host_irq_n_out,
  output logic             host_irq_n_oe,
  output logic             divided_freq_out
);

  // Pin synchronisation
  logic [`RTCMHP_SYNC_W-1:0] pins_raw;
  logic [`RTCMHP_SYNC_W-1:0] pins_s;
  logic [`RTCMHP_SYNC_W-1:0] pins_prev_reg;

  assign pins_raw = {shared_addr_data_lines_in, addr_latch_strobe, read_strobe_n,
                     write_strobe_n, dev_select_n, bus_style_select, host_reset_n,
                     main_power_valid, osc_tick_in, ext_ram_enable_in_n};

  rtcmhp_sync #(
    .W   (`RTCMHP_SYNC_W),
    .RST (`RTCMHP_SYNC_RST)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (pins_raw),
    .q_out   (pins_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev_reg <= `RTCMHP_SYNC_RST;
    end else begin
      pins_prev_reg <= pins_s;
    end
  end

  rtcmhp_byte_t ad_s;
  logic         ale_s, rd_n_s, wr_n_s, cs_n_s, style_s, hrst_n_s, pwr_s, osc_s, ce_n_s;
  logic         ale_prev, rd_n_prev, wr_n_prev, pwr_prev, osc_prev;

  assign {ad_s, ale_s, rd_n_s, wr_n_s, cs_n_s, style_s, hrst_n_s, pwr_s, osc_s, ce_n_s} = pins_s;
  assign ale_prev  = pins_prev_reg[8];
  assign rd_n_prev = pins_prev_reg[7];
  assign wr_n_prev = pins_prev_reg[6];
  assign pwr_prev  = pins_prev_reg[2];
  assign osc_prev  = pins_prev_reg[1];
  logic ale_fall, rd_fall, rd_rise, wr_rise, pwr_fall, osc_rise;
  assign ale_fall = ale_prev & ~ale_s;
  assign rd_fall  = rd_n_prev & ~rd_n_s;
  assign rd_rise  = ~rd_n_prev & rd_n_s;
  assign wr_rise  = ~wr_n_prev & wr_n_s;
  assign pwr_fall = pwr_prev & ~pwr_s;
  assign osc_rise = ~osc_prev & osc_s;

  // APB registers
  logic [`RTCMHP_IRQ_W-1:0] irq_status_reg;
  logic [`RTCMHP_IRQ_W-1:0] irq_mask_reg;
  logic                     port_en_reg;
  logic [`RTCMHP_IRQ_W-1:0] irq_set;
  logic                     apb_wr;
  logic                     apb_mapped;
  logic                     trig_alarm;
  logic                     trig_update;

  // Host-side state
  rtcmhp_phase_e            phase_reg;
  rtcmhp_byte_t             addr_reg;
  logic [6:0]               reg_a_reg;
  rtcmhp_byte_t             reg_b_reg;
  rtcmhp_flags_t            flags_reg;
  logic                     summary_reg;
  rtcmhp_byte_t             rd_byte;
  rtcmhp_byte_t             mem [`RTCMHP_MEM_DEPTH];
  logic [`RTCMHP_DIV_W-1:0] div_reg;
  logic                     tap_reg;
  logic                     port_ok;
  logic                     host_rd_start;
  logic                     host_wr_done;
  logic                     clr_flags;

  // RQ8 RQ13 port gating
  // A reset pin held low or a wrong bus style locks the port out
  assign port_ok = hrst_n_s & ~style_s & port_en_reg;

  // RQ1 RQ3 bus phase tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_IDLE;
    end else if (!port_ok) begin
      phase_reg <= PH_IDLE;
    end else begin
      unique case (phase_reg)
        PH_IDLE:  if (ale_s) phase_reg <= PH_ADDR;
        PH_ADDR:  if (ale_fall) phase_reg <= PH_DATA;
        PH_DATA: begin
          if (ale_s) begin
            phase_reg <= PH_ADDR;
          end else if (rd_fall && !cs_n_s) begin
            phase_reg <= PH_READ;
          end else if (!wr_n_s && !cs_n_s) begin
            phase_reg <= PH_WRITE;
          end
        end
        PH_READ:  if (rd_rise || cs_n_s) phase_reg <= PH_DATA;
        PH_WRITE: if (wr_rise) phase_reg <= PH_DATA;
        default:  phase_reg <= PH_IDLE;
      endcase
    end
  end

  // RQ2 RQ5 RQ18 address latch
  // Select is not looked at, so the latch follows every bus cycle while the reset pin is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 8'h00;
    end else if (ale_fall && hrst_n_s) begin
      addr_reg <= ad_s;
    end
  end

  // RQ6 read start
  assign host_rd_start = port_ok && phase_reg == PH_DATA && !ale_s && rd_fall && !cs_n_s;
  // RQ7 RQ4 write completion
  assign host_wr_done  = port_ok && phase_reg == PH_WRITE && wr_rise && !cs_n_s;
  // RQ16 RQ12 flag clear on read of the flag register
  assign clr_flags     = host_rd_start && addr_reg == `RTCMHP_REG_C;

  always_comb begin
    rd_byte = 8'h00;
    unique case (addr_reg)
      `RTCMHP_REG_A: rd_byte = {1'b0, reg_a_reg};
      `RTCMHP_REG_B: rd_byte = reg_b_reg;
      `RTCMHP_REG_C: rd_byte = {summary_reg, flags_reg, 4'h0};
      `RTCMHP_REG_D: rd_byte = {pwr_s, 7'h00};
      default:       rd_byte = addr_reg[7] ? 8'h00 : mem[addr_reg[6:0]];
    endcase
  end

  // RQ3 RQ6 data drivers
  // Read data is frozen at the strobe edge so a flag clear cannot alter it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_addr_data_lines_out <= 8'h00;
      shared_addr_data_lines_oe  <= 1'b0;
    end else if (host_rd_start) begin
      shared_addr_data_lines_out <= rd_byte;
      shared_addr_data_lines_oe  <= 1'b1;
    end else if (phase_reg != PH_READ || rd_rise || cs_n_s || !port_ok) begin
      shared_addr_data_lines_oe  <= 1'b0;
    end
  end

  // RQ7 RQ15 host register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_a_reg <= `RTCMHP_RA_RST;
      reg_b_reg <= `RTCMHP_RB_RST;
    end else if (!hrst_n_s) begin
      // RQ13 reset pin clears enables
      reg_b_reg <= reg_b_reg & ~`RTCMHP_RB_HRST_CLR;
    end else if (host_wr_done && pwr_s) begin
      if (addr_reg == `RTCMHP_REG_A) begin
        reg_a_reg <= ad_s[6:0];
      end else if (addr_reg == `RTCMHP_REG_B) begin
        reg_b_reg <= ad_s;
      end
    end
  end

  // RQ15 storage writes blocked without power
  // Storage holds no reset so contents survive a bus reset
  always_ff @(posedge pclk) begin
    if (host_wr_done && pwr_s && !addr_reg[7] && addr_reg != `RTCMHP_REG_A
        && addr_reg != `RTCMHP_REG_B && addr_reg != `RTCMHP_REG_C
        && addr_reg != `RTCMHP_REG_D) begin
      mem[addr_reg[6:0]] <= ad_s;
    end
  end

  // RQ17 rate field tap select
  function automatic logic tap_of(input logic [3:0] rate, input logic [`RTCMHP_DIV_W-1:0] d);
    logic t;
    t = 1'b0;
    unique case (rate)
      4'h0:    t = 1'b0;
      4'h1:    t = d[6];
      4'h2:    t = d[7];
      default: t = d[4'(rate - 4'h2)];
    endcase
    return t;
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
      tap_reg <= 1'b0;
    end else begin
      if (osc_rise) begin
        div_reg <= div_reg + 1'b1;
      end
      tap_reg <= tap_of(reg_a_reg[3:0], div_reg);
    end
  end
  logic tap_now;
  logic period_evt;
  assign tap_now    = tap_of(reg_a_reg[3:0], div_reg);
  assign period_evt = tap_reg & ~tap_now;

  // RQ9 RQ10 frequency output gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divided_freq_out <= 1'b0;
    end else begin
      divided_freq_out <= pwr_s & reg_b_reg[`RTCMHP_RB_FREQ_EN] & tap_now;
    end
  end

  // RQ11 RQ16 event flags
  // New events win over a clear in the same cycle
  rtcmhp_flags_t flags_set;
  rtcmhp_flags_t flags_next;
  rtcmhp_flags_t flags_en;
  logic          summary_next;
  assign flags_set    = {period_evt, trig_alarm, trig_update};
  assign flags_en     = {reg_b_reg[`RTCMHP_RB_PER_IE], reg_b_reg[`RTCMHP_RB_ALM_IE],
                         reg_b_reg[`RTCMHP_RB_UPD_IE]};
  assign flags_next   = (clr_flags ? 3'b000 : flags_reg) | flags_set;
  assign summary_next = ((clr_flags ? 1'b0 : summary_reg) | |(flags_set & flags_en));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg   <= 3'b000;
      summary_reg <= 1'b0;
    end else if (!hrst_n_s) begin
      flags_reg   <= 3'b000;
      summary_reg <= 1'b0;
    end else begin
      flags_reg   <= flags_next;
      summary_reg <= summary_next;
    end
  end

  // RQ11 RQ12 RQ13 open-drain interrupt
  assign host_irq_n_out = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_irq_n_oe <= 1'b0;
    end else begin
      host_irq_n_oe <= hrst_n_s & |(flags_next & flags_en) & ~(clr_flags & ~|flags_set);
    end
  end

  // RQ14 external RAM enable pass-through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ram_enable_out_n <= 1'b1;
    end else begin
      ext_ram_enable_out_n <= pwr_s ? ce_n_s : 1'b1;
    end
  end

  // APB slave, zero wait states
  assign pready     = 1'b1;
  assign apb_mapped = paddr == `RTCMHP_APB_IRQ_STATUS || paddr == `RTCMHP_APB_IRQ_MASK
                   || paddr == `RTCMHP_APB_CTRL || paddr == `RTCMHP_APB_PORT_STAT
                   || paddr == `RTCMHP_APB_EVT_TRIG;
  assign pslverr    = psel & penable & ~apb_mapped;
  assign apb_wr     = psel & penable & pwrite & apb_mapped;
  assign trig_alarm  = apb_wr && paddr == `RTCMHP_APB_EVT_TRIG
                    && pwdata[`RTCMHP_TRIG_ALARM];
  assign trig_update = apb_wr && paddr == `RTCMHP_APB_EVT_TRIG
                    && pwdata[`RTCMHP_TRIG_UPDATE];

  // Read data settles in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `RTCMHP_APB_IRQ_STATUS: prdata <= {28'h0, irq_status_reg};
          `RTCMHP_APB_IRQ_MASK:   prdata <= {28'h0, irq_mask_reg};
          `RTCMHP_APB_CTRL:       prdata <= {31'h0, port_en_reg};
          `RTCMHP_APB_PORT_STAT:  prdata <= {13'h0, ~hrst_n_s, host_irq_n_oe, pwr_s,
                                             summary_reg, flags_reg, 4'h0, addr_reg};
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= '0;
      port_en_reg  <= `RTCMHP_CTRL_RST;
    end else if (apb_wr) begin
      if (paddr == `RTCMHP_APB_IRQ_MASK) begin
        irq_mask_reg <= pwdata[`RTCMHP_IRQ_W-1:0];
      end
      if (paddr == `RTCMHP_APB_CTRL) begin
        port_en_reg <= pwdata[`RTCMHP_CTRL_PORT_EN];
      end
    end
  end

  // Sticky status, write one to clear, set wins
  logic host_int_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_int_prev_reg <= 1'b0;
    end else begin
      host_int_prev_reg <= host_irq_n_oe;
    end
  end
  // Order follows the status bit positions
  assign irq_set = {host_irq_n_oe & ~host_int_prev_reg, pwr_fall, host_rd_start, host_wr_done};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else if (apb_wr && paddr == `RTCMHP_APB_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~pwdata[`RTCMHP_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);
endmodule

// ---- verification/rtcmhp_top_sva.sv ----
// Port-level checker for the clock/calendar host port
`timescale 1ns/100ps
module rtcmhp_top_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       shared_addr_data_lines_oe,
  input wire logic       read_strobe_n,
  input wire logic       dev_select_n,
  input wire logic       host_reset_n,
  input wire logic       main_power_valid,
  input wire logic       ext_ram_enable_in_n,
  input wire logic       ext_ram_enable_out_n,
  input wire logic       host_irq_n_out,
  input wire logic       host_irq_n_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel |-> pready)
    else $error("pready low in transfer");
  apb_err_a: assert property (pslverr == (psel && penable &&
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})))
    else $error("pslverr wrong");
  ce_block_a: assert property (!main_power_valid [*4] |-> ext_ram_enable_out_n)
    else $error("ram enable passed without power");
  ce_follow_a: assert property ((main_power_valid && !ext_ram_enable_in_n) [*5]
    |-> !ext_ram_enable_out_n)
    else $error("ram enable not passed");
  rd_drive_a: assert property ($fell(read_strobe_n) && !dev_select_n && host_reset_n
    |-> ##[2:6] shared_addr_data_lines_oe)
    else $error("no drive on read");
  rd_release_a: assert property ($rose(read_strobe_n) |-> ##[1:6] !shared_addr_data_lines_oe)
    else $error("drive kept after read");
  sel_refuse_a: assert property (dev_select_n [*5] |-> !shared_addr_data_lines_oe)
    else $error("drive while deselected");
  hrst_float_a: assert property (!host_reset_n [*5]
    |-> !host_irq_n_oe && !shared_addr_data_lines_oe)
    else $error("pins driven in host reset");
  od_level_a: assert property (host_irq_n_oe |-> !host_irq_n_out)
    else $error("interrupt pin not pulled low");
  cover property ($rose(host_irq_n_oe));
  cover property ($rose(shared_addr_data_lines_oe));
  cover property (pslverr);
endmodule

bind rtcmhp_top rtcmhp_top_sva i_sva (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .shared_addr_data_lines_oe, .read_strobe_n, .dev_select_n,
  .host_reset_n, .main_power_valid, .ext_ram_enable_in_n, .ext_ram_enable_out_n,
  .host_irq_n_out, .host_irq_n_oe);

// ---- verification/rtcmhp_host_model.sv ----
// Microprocessor on the multiplexed address/data bus
`timescale 1ns/100ps
module rtcmhp_host_model (
  input  wire logic       pclk,
  input  wire logic [7:0] dev_out,
  input  wire logic       dev_oe,
  output logic      [7:0] ad,
  output logic            ale,
  output logic            rd_n,
  output logic            wr_n,
  output logic            cs_n
);
  logic [7:0] h_d;
  logic       h_oe;
  // Undriven lines flip so a stale byte never reads as good
  assign ad = dev_oe ? dev_out : (h_oe ? h_d : ~h_d);
  initial begin
    h_d = 8'h00;
    h_oe = 1'b0;
    ale = 1'b0;
    {rd_n, wr_n, cs_n} = 3'h7;
  end
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic addr(input logic [7:0] a, input logic sel_n);
    @(posedge pclk);
    h_d <= a;
    h_oe <= 1'b1;
    ale <= 1'b1;
    cs_n <= sel_n;
    step(6);
    ale <= 1'b0;
    step(6);
    h_oe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr(a, 1'b0);
    @(posedge pclk);
    h_d <= d;
    h_oe <= 1'b1;
    wr_n <= 1'b0;
    step(6);
    wr_n <= 1'b1;
    step(6);
    cs_n <= 1'b1;
    h_oe <= 1'b0;
    step(6);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic oe);
    addr(a, 1'b0);
    @(posedge pclk);
    rd_n <= 1'b0;
    step(8);
    q = ad;
    oe = dev_oe;
    rd_n <= 1'b1;
    step(6);
    cs_n <= 1'b1;
    step(6);
  endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench of the clock/calendar host port
`timescale 1ns/100ps
`include "rtcmhp_consts.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, shared_addr_data_lines_in, shared_addr_data_lines_out, hq;
  logic [31:0] pwdata, prdata, q;
  logic        shared_addr_data_lines_oe, addr_latch_strobe, read_strobe_n, hoe;
  logic        write_strobe_n, dev_select_n, host_reset_n, main_power_valid;
  logic        ext_ram_enable_in_n, ext_ram_enable_out_n, host_irq_n_out;
  logic        host_irq_n_oe, divided_freq_out, bus_style_select;
  logic [2:0]  oc;
  int          n_fail, num_checks;
  rtcmhp_top i_rtcmhp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .shared_addr_data_lines_in,
    .shared_addr_data_lines_out, .shared_addr_data_lines_oe, .addr_latch_strobe,
    .read_strobe_n, .write_strobe_n, .dev_select_n, .bus_style_select,
    .host_reset_n, .main_power_valid, .osc_tick_in(oc[2]), .ext_ram_enable_in_n,
    .ext_ram_enable_out_n, .host_irq_n_out, .host_irq_n_oe, .divided_freq_out);
  rtcmhp_host_model host (.pclk, .dev_out(shared_addr_data_lines_out),
    .dev_oe(shared_addr_data_lines_oe), .ad(shared_addr_data_lines_in),
    .ale(addr_latch_strobe), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
    .cs_n(dev_select_n));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Time base runs at one eighth of pclk
  always @(posedge pclk) oc <= oc + 3'h1;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_fail++;
      tally_and_finish();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_apb;
    apb(1'b0, `RTCMHP_APB_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h0, q);
    apb(1'b0, `RTCMHP_APB_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, q);
    apb(1'b1, `RTCMHP_APB_IRQ_MASK, 32'hf);
    apb(1'b0, `RTCMHP_APB_IRQ_MASK, 32'h0);
    chk("mask rw", 32'hf, q);
    apb(1'b1, `RTCMHP_APB_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, q);
    $display("done t_apb");
  endtask
  task automatic t_bus;
    host.wr(8'h20, 8'h5a);
    host.rd(8'h20, hq, hoe);
    chk("read drive", 32'h1, {31'h0, hoe});
    chk("storage byte", 32'h5a, {24'h0, hq});
    host.addr(8'h33, 1'b1);
    apb(1'b0, `RTCMHP_APB_PORT_STAT, 32'h0);
    chk("latched addr", 32'h33, {24'h0, q[7:0]});
    $display("done t_bus");
  endtask
  task automatic t_pwr;
    ext_ram_enable_in_n <= 1'b0;
    wt(6);
    chk("ram enable on", 32'h0, {31'h0, ext_ram_enable_out_n});
    main_power_valid <= 1'b0;
    wt(6);
    chk("ram enable off", 32'h1, {31'h0, ext_ram_enable_out_n});
    host.wr(8'h20, 8'ha5);
    main_power_valid <= 1'b1;
    wt(6);
    host.rd(8'h20, hq, hoe);
    chk("protected byte", 32'h5a, {24'h0, hq});
    apb(1'b0, `RTCMHP_APB_IRQ_STATUS, 32'h0);
    chk("event status", 32'h7, q);
    $display("done t_pwr");
  endtask
  task automatic t_irq;
    host.wr(`RTCMHP_REG_B, 8'h20);
    apb(1'b1, `RTCMHP_APB_EVT_TRIG, 32'h3);
    wt(4);
    chk("int pulled", 32'h1, {31'h0, host_irq_n_oe});
    apb(1'b1, `RTCMHP_APB_IRQ_MASK, 32'h8);
    wt(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    host.rd(`RTCMHP_REG_C, hq, hoe);
    chk("flags", 32'hb0, {24'h0, hq});
    chk("int released", 32'h0, {31'h0, host_irq_n_oe});
    host.rd(`RTCMHP_REG_C, hq, hoe);
    chk("flags cleared", 32'h0, {24'h0, hq});
    apb(1'b1, `RTCMHP_APB_IRQ_STATUS, 32'hf);
    wt(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("done t_irq");
  endtask
  task automatic per(input logic [31:0] e);
    int k, r, t;
    logic f;
    k = 0;
    r = 0;
    t = 0;
    f = divided_freq_out;
    // Edges from first rise to second; t bounds the whole wait
    while (r < 2 && t < 4000) begin
      @(posedge pclk);
      t++;
      if (r == 1) k++;
      if (divided_freq_out === 1'b1 && f === 1'b0) r++;
      f = divided_freq_out;
    end
    if (t >= 4000) begin
      n_fail++;
      tally_and_finish();
    end
    chk("freq period", e, k);
  endtask
  task automatic t_freq;
    int k;
    host.wr(`RTCMHP_REG_A, 8'h03);
    host.wr(`RTCMHP_REG_B, 8'h08);
    per(32'd32);
    host.wr(`RTCMHP_REG_A, 8'h04);
    per(32'd64);
    host.wr(`RTCMHP_REG_B, 8'h00);
    wt(8);
    k = 0;
    repeat (100) begin
      @(posedge pclk);
      if (divided_freq_out !== 1'b0) k++;
    end
    chk("freq gated", 32'h0, k);
    $display("done t_freq");
  endtask
  task automatic t_hrst;
    host.wr(`RTCMHP_REG_B, 8'h78);
    host_reset_n <= 1'b0;
    wt(6);
    apb(1'b0, `RTCMHP_APB_PORT_STAT, 32'h0);
    chk("host reset seen", 32'h1, {31'h0, q[18]});
    host.rd(8'h20, hq, hoe);
    chk("no drive in reset", 32'h0, {31'h0, hoe});
    host_reset_n <= 1'b1;
    wt(6);
    host.rd(`RTCMHP_REG_B, hq, hoe);
    chk("reg b cleared", 32'h0, {24'h0, hq});
    $display("done t_hrst");
  endtask
  task automatic t_style;
    bus_style_select <= 1'b1;
    wt(4);
    host.wr(8'h20, 8'hc3);
    bus_style_select <= 1'b0;
    apb(1'b1, `RTCMHP_APB_CTRL, 32'h0);
    host.wr(8'h20, 8'h3c);
    apb(1'b1, `RTCMHP_APB_CTRL, 32'h1);
    wt(4);
    host.rd(8'h20, hq, hoe);
    chk("locked out byte", 32'h5a, {24'h0, hq});
    $display("done t_style");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, oc} = 7'h0;
    {paddr, pwdata} = 40'h0;
    {host_reset_n, main_power_valid, ext_ram_enable_in_n} = 3'h7;
    bus_style_select = 1'b0;
    n_fail = 0;
    num_checks = 0;
    wt(3);
    presetn <= 1'b1;
    wt(6);
    t_apb();
    t_bus();
    t_pwr();
    t_irq();
    t_freq();
    t_hrst();
    t_style();
    tally_and_finish();
  end
endmodule
